// [rtl/flash_host_ctrl.sv]
// Functional notes
// RULE1 - program is two unlocks, set-up command, then address with data byte.
// RULE2 - device makes its own program pulses; host just waits for ready.
// RULE3 - after an algorithm the device is back in read mode.
// RULE4 - device ignores commands while programming; host sends none then.
// RULE5 - hardware reset aborts programming; reissue once back in read mode.
// RULE6 - programming only clears bits; a 1 needs an erase.
// RULE7 - bytes may be programmed in any address order.
// RULE8 - chip erase is six writes: unlocks, set-up, unlocks, chip erase.
// RULE9 - the erase algorithm preprograms itself; host never preprograms.
// RULE10 - chip erase ignores commands; only hardware reset stops it.
// RULE11 - sector erase is six writes ending with sector address and erase command.
// RULE12 - a 50 us window accepts further sector erase writes.
// RULE13 - window timer starts on the rising write strobe of the last write.
// RULE14 - host spaces extra sector writes under 50 us apart.
// RULE15 - any other command in the window returns device to read mode.
// RULE16 - device shows a flag telling whether the window has expired.
// RULE17 - during sector erase only suspend is accepted; reset pin aborts.
// RULE18 - suspend works only in sector erase or its window; address ignored.
// RULE19 - suspend takes at most 20 us, or at once within the window.
// RULE20 - while suspended, other sectors read and program normally.
// RULE21 - identification read allowed while suspended; exit restores suspend.
// RULE22 - resume continues the erase; repeats ignored; suspend may follow again.
// RULE23 - polling bit or both toggle bits tell erasing from suspended.
// RULE24 - address taken at later falling edge, data at first rising edge.
// RULE25 - wrong or misordered writes send the device back to read mode.
// RULE26 - write only with select and write strobe low, output strobe high.
// RULE27 - sector chosen by the upper six address bits.
// RULE28 - algorithm durations hold ready_busy_n low throughout.
// RULE29 - suspend, resume and reset checked every cycle; suspend and resume are refused here while the sequencer is busy.
module flash_host_ctrl #(
  parameter int WINDOW_CYCLES = flash_host_pkg::WINDOW_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output flash_host_pkg::flash_bus_t flash_q,
  input wire logic [7:0] flash_dq_in,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_gap, st_rst_pulse, st_rst_wait,
                            st_busy_wait} state_t;

  // ==========================================================
  // command sequence table
  function automatic logic [29:0] step_word(input logic [2:0] op, input logic [2:0] idx,
                                            input logic [21:0] a, input logic [7:0] d);
    logic [29:0] w;
    w = {a, d};
    case (op)
      flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE: begin
        case (idx)
          3'h0: w = {flash_host_pkg::ADDR_UNLOCK1, flash_host_pkg::CMD_UNLOCK1}; // [RULE1] [RULE8] [RULE11]
          3'h1: w = {flash_host_pkg::ADDR_UNLOCK2, flash_host_pkg::CMD_UNLOCK2};
          3'h2: w = {flash_host_pkg::ADDR_UNLOCK1, (op == flash_host_pkg::OP_PROGRAM) ?
                     flash_host_pkg::CMD_PROGRAM : flash_host_pkg::CMD_ERASE_SETUP};
          3'h3: w = (op == flash_host_pkg::OP_PROGRAM) ? {a, d} :
                    {flash_host_pkg::ADDR_UNLOCK1, flash_host_pkg::CMD_UNLOCK1};
          3'h4: w = {flash_host_pkg::ADDR_UNLOCK2, flash_host_pkg::CMD_UNLOCK2};
          default: w = (op == flash_host_pkg::OP_CHIP_ERASE) ?
                       {flash_host_pkg::ADDR_UNLOCK1, flash_host_pkg::CMD_CHIP_ERASE} :
                       {a, flash_host_pkg::CMD_SECTOR_ERASE}; // [RULE27]
        endcase
      end
      flash_host_pkg::OP_ADD_SECTOR: w = {a, flash_host_pkg::CMD_SECTOR_ERASE}; // [RULE12]
      flash_host_pkg::OP_SUSPEND: w = {flash_host_pkg::ADDR_DONT_CARE, flash_host_pkg::CMD_SUSPEND}; // [RULE18]
      flash_host_pkg::OP_RESUME: w = {flash_host_pkg::ADDR_DONT_CARE, flash_host_pkg::CMD_RESUME}; // [RULE22]
      flash_host_pkg::OP_RESET_CMD: w = {flash_host_pkg::ADDR_DONT_CARE, flash_host_pkg::CMD_RESET};
      default: w = {a, 8'h00};
    endcase
    return w;
  endfunction

  function automatic logic [2:0] seq_len(input logic [2:0] op);
    logic [2:0] n;
    n = flash_host_pkg::LEN_SINGLE;
    if (op == flash_host_pkg::OP_PROGRAM) begin
      n = flash_host_pkg::LEN_PROGRAM;
    end else if (op == flash_host_pkg::OP_CHIP_ERASE || op == flash_host_pkg::OP_SECTOR_ERASE) begin
      n = flash_host_pkg::LEN_ERASE;
    end
    return n;
  endfunction

  state_t state_q, state_d;
  logic [15:0] tmr_q;
  logic [2:0] idx_q, op_q;
  logic [21:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic refused_q, pending_q;
  logic [15:0] win_q;

  // ==========================================================
  // wishbone decode
  wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]; // lands where master sees ack
  wire logic ctrl_wr = bus_wr && wb_adr_i == flash_host_pkg::REG_CTRL;
  wire logic idle = state_q == st_idle;
  wire logic win_open = pending_q && win_q < 16'(WINDOW_CYCLES);
  wire logic [2:0] new_op = wb_dat_i[flash_host_pkg::CTRL_OP_LSB +: 3];
  wire logic hw_rst_req = ctrl_wr && wb_dat_i[flash_host_pkg::CTRL_HWRST_BIT];
  // an added sector outside the window could start erasing early, so refuse it
  wire logic add_bad = new_op == flash_host_pkg::OP_ADD_SECTOR && !win_open; // [RULE14]
  wire logic start = ctrl_wr && idle && !hw_rst_req && !add_bad;
  wire logic refuse = ctrl_wr && !hw_rst_req && (!idle || add_bad);
  wire logic clr_refused = bus_wr && wb_adr_i == flash_host_pkg::REG_STATUS && wb_dat_i[flash_host_pkg::ST_REFUSED_BIT];
  wire logic last_step = idx_q == seq_len(op_q) - 3'h1;
  wire logic is_read = op_q == flash_host_pkg::OP_READ;
  wire logic waits_ready = op_q == flash_host_pkg::OP_PROGRAM || op_q == flash_host_pkg::OP_CHIP_ERASE;
  wire logic tmr_done = tmr_q == 16'h0000;
  // setup loads the pins from the step that comes next, not from the one just ended
  wire logic [2:0] op_d = start ? new_op : op_q;
  wire logic [2:0] idx_d = start ? 3'h0 : (state_q == st_gap && tmr_done && !last_step) ? idx_q + 3'h1 : idx_q;
  wire logic read_d = op_d == flash_host_pkg::OP_READ;
  wire logic [29:0] cur_word = step_word(op_d, idx_d, addr_q, wdata_q);
  wire logic erase_mark = state_q == st_strobe && tmr_done && last_step &&
                          (op_q == flash_host_pkg::OP_SECTOR_ERASE || op_q == flash_host_pkg::OP_ADD_SECTOR);
  wire logic [31:0] status_word = {27'h0000000, pending_q, win_open, refused_q, ready_busy_n, !idle};
  wire logic [31:0] rd_mux = (wb_adr_i == flash_host_pkg::REG_ADDR) ? {10'h000, addr_q} :
                             (wb_adr_i == flash_host_pkg::REG_WDATA) ? {24'h000000, wdata_q} :
                             (wb_adr_i == flash_host_pkg::REG_STATUS) ? status_word :
                             (wb_adr_i == flash_host_pkg::REG_RDATA) ? {24'h000000, rdata_q} : 32'h00000000;

  // ==========================================================
  // bus slave, ack one cycle after the request
  always_ff @(posedge clock) begin
    wb_ack_o <= !rst && bus_req;
    wb_dat_o <= rst ? 32'h00000000 : rd_mux;
    if (rst) begin
      addr_q <= 22'h000000;
      wdata_q <= 8'h00;
    end else if (bus_wr && idle && wb_adr_i == flash_host_pkg::REG_ADDR) begin
      addr_q <= wb_dat_i[21:0];
    end else if (bus_wr && idle && wb_adr_i == flash_host_pkg::REG_WDATA) begin
      wdata_q <= wb_dat_i[7:0];
    end
  end

  // sticky refusal, a new refusal beats the clear
  always_ff @(posedge clock) begin
    refused_q <= !rst && (refuse || (refused_q && !clr_refused));
  end

  // window timer restarts at the rising strobe of each sector write
  always_ff @(posedge clock) begin
    if (rst || hw_rst_req) begin
      pending_q <= 1'b0;
      win_q <= 16'h0000;
    end else if (erase_mark) begin
      pending_q <= 1'b1; // [RULE13]
      win_q <= 16'h0000;
    end else if (start && new_op != flash_host_pkg::OP_ADD_SECTOR) begin
      pending_q <= 1'b0; // [RULE15] [RULE19]
    end else if (win_q != 16'hFFFF) begin
      win_q <= win_q + 16'h0001;
    end
  end

  // ==========================================================
  // pin sequencer, next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: state_d = hw_rst_req ? st_rst_pulse : (start ? st_setup : st_idle);
      st_setup: state_d = st_strobe;
      st_strobe: state_d = tmr_done ? st_hold : st_strobe;
      st_hold: state_d = st_gap;
      st_gap: state_d = !tmr_done ? st_gap : (!last_step ? st_setup : (waits_ready ? st_busy_wait : st_idle));
      st_rst_pulse: state_d = tmr_done ? st_rst_wait : st_rst_pulse;
      st_rst_wait: state_d = tmr_done && ready_busy_n ? st_idle : st_rst_wait; // [RULE5]
      st_busy_wait: state_d = tmr_done && ready_busy_n ? st_idle : st_busy_wait; // [RULE2] [RULE3] [RULE28]
      default: state_d = st_idle;
    endcase
    if (hw_rst_req) begin
      state_d = st_rst_pulse; // [RULE29]
    end
  end

  // sequencer registers and pins; strobes released before data so data is latched cleanly
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= st_idle;
      tmr_q <= 16'h0000;
      idx_q <= 3'h0;
      op_q <= flash_host_pkg::OP_READ;
      rdata_q <= 8'h00;
      flash_q <= flash_host_pkg::FLASH_IDLE;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      idx_q <= idx_d; // [RULE25]
      if (state_q == st_strobe && tmr_done && is_read) begin
        rdata_q <= flash_dq_in;
      end
      case (state_d)
        st_setup: begin
          tmr_q <= 16'(read_d ? flash_host_pkg::READ_CYC : flash_host_pkg::WE_LOW_CYC);
          flash_q <= '{reset_n: 1'b1, ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: read_d,
                       addr: cur_word[29:8], dq_out: cur_word[7:0]}; // [RULE24]
        end
        st_strobe: begin
          tmr_q <= tmr_done ? 16'h0000 : tmr_q - 16'h0001;
          flash_q.we_n <= is_read; // [RULE26]
          flash_q.oe_n <= !is_read;
        end
        st_hold: begin
          flash_q.we_n <= 1'b1;
          flash_q.oe_n <= 1'b1;
          tmr_q <= 16'(flash_host_pkg::GAP_CYC);
        end
        st_gap: begin
          flash_q.ce_n <= 1'b1;
          flash_q.dq_oe_n <= 1'b1;
          tmr_q <= tmr_done ? 16'h0000 : tmr_q - 16'h0001;
        end
        st_rst_pulse: begin
          flash_q <= '{reset_n: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1,
                       addr: 22'h000000, dq_out: 8'h00};
          tmr_q <= (state_q != st_rst_pulse) ? 16'(flash_host_pkg::RESET_LOW_CYC - 1) :
                   (tmr_done ? 16'(flash_host_pkg::RDY_SETTLE_CYC - 1) : tmr_q - 16'h0001);
        end
        st_rst_wait, st_busy_wait: begin
          flash_q.reset_n <= 1'b1;
          // ready_busy_n is only valid a short time after the last strobe
          tmr_q <= (state_q == st_gap || state_q == st_rst_pulse) ? 16'(flash_host_pkg::RDY_SETTLE_CYC - 1) :
                   (tmr_done ? 16'h0000 : tmr_q - 16'h0001);
        end
        default: begin
          flash_q.reset_n <= 1'b1;
          tmr_q <= 16'h0000;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  chk_write_strobe_excl: assert property (@(posedge clock) disable iff (rst) // [RULE26]
    !flash_q.we_n |-> flash_q.oe_n && !flash_q.ce_n && !flash_q.dq_oe_n)
    else $error("write strobe low without select, or with output strobe low");
  chk_strobe_width: assert property (@(posedge clock) disable iff (rst) // [RULE24]
    $fell(flash_q.we_n) |-> !flash_q.we_n [*5] ##1 flash_q.we_n && !flash_q.ce_n)
    else $error("write strobe width wrong or select released first");
  chk_program_unlock: assert property (@(posedge clock) disable iff (rst) // [RULE1]
    start && new_op == flash_host_pkg::OP_PROGRAM |-> ##2 flash_q.addr == flash_host_pkg::ADDR_UNLOCK1 &&
    flash_q.dq_out == flash_host_pkg::CMD_UNLOCK1)
    else $error("program sequence does not open with first unlock");
  chk_chip_last_cmd: assert property (@(posedge clock) disable iff (rst) // [RULE8]
    !flash_q.we_n && op_q == flash_host_pkg::OP_CHIP_ERASE && idx_q == 3'h5 |->
    flash_q.dq_out == flash_host_pkg::CMD_CHIP_ERASE)
    else $error("chip erase sixth write carries wrong command");
  chk_sector_bits: assert property (@(posedge clock) disable iff (rst) // [RULE27]
    !flash_q.we_n && op_q == flash_host_pkg::OP_SECTOR_ERASE && idx_q == 3'h5 |->
    flash_q.addr[flash_host_pkg::SECTOR_MSB:flash_host_pkg::SECTOR_LSB] ==
    addr_q[flash_host_pkg::SECTOR_MSB:flash_host_pkg::SECTOR_LSB] && flash_q.dq_out == flash_host_pkg::CMD_SECTOR_ERASE)
    else $error("sector erase write has wrong sector or command");
  chk_add_in_window: assert property (@(posedge clock) disable iff (rst) // [RULE14]
    ctrl_wr && !hw_rst_req && new_op == flash_host_pkg::OP_ADD_SECTOR && !win_open |=> refused_q)
    else $error("extra sector write outside the window not refused");
  chk_reset_pulse: assert property (@(posedge clock) disable iff (rst) // [RULE5]
    $fell(flash_q.reset_n) |-> !flash_q.reset_n [*8])
    else $error("reset pulse too short");
  chk_busy_release: assert property (@(posedge clock) disable iff (rst) // [RULE28]
    state_q == st_busy_wait && tmr_done && ready_busy_n && !hw_rst_req |=> idle)
    else $error("sequencer did not leave busy wait on ready");
  chk_no_cmd_busy: assert property (@(posedge clock) disable iff (rst) // [RULE4]
    state_q == st_busy_wait |-> flash_q.we_n && flash_q.ce_n)
    else $error("command written while device is busy");
  chk_ack_pulse: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  cov_program: cover property (@(posedge clock) disable iff (rst)
    state_q == st_busy_wait && op_q == flash_host_pkg::OP_PROGRAM ##1 idle);
  cov_add_sector: cover property (@(posedge clock) disable iff (rst)
    start && new_op == flash_host_pkg::OP_ADD_SECTOR);
  cov_read: cover property (@(posedge clock) disable iff (rst)
    state_q == st_strobe && is_read && tmr_done);
  cov_hw_reset: cover property (@(posedge clock) disable iff (rst)
    state_q == st_rst_wait ##1 idle);
endmodule // flash_host_ctrl

// [rtl/flash_host_pkg.sv]
package flash_host_pkg;
  // ==========================================================
  // register map of the controller, word aligned
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_HWRST_BIT = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RDY_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_WINDOW_BIT = 3;
  localparam int ST_PENDING_BIT = 4;

  // ==========================================================
  // operations that software may order
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] OP_ADD_SECTOR = 3'h4;
  localparam logic [2:0] OP_SUSPEND = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_RESET_CMD = 3'h7;

  // ==========================================================
  // device command codes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
  localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002AA;
  localparam logic [21:0] ADDR_DONT_CARE = 22'h000000;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_MSB = 21;
  localparam logic [2:0] LEN_PROGRAM = 3'h4;
  localparam logic [2:0] LEN_ERASE = 3'h6;
  localparam logic [2:0] LEN_SINGLE = 3'h1;

  // ==========================================================
  // timing, figures in their own unit, counts derived at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int WE_LOW_NS = 50;
  localparam int READ_NS = 90;
  localparam int GAP_NS = 20;
  localparam int RESET_LOW_NS = 500;
  localparam int RDY_SETTLE_NS = 100;
  localparam int WINDOW_US = 50;
  localparam int WINDOW_MARGIN_US = 10;
  localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RDY_SETTLE_CYC = (RDY_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // longest safe spacing, the window less a 10 us margin
  localparam int WINDOW_CYC = (WINDOW_US - WINDOW_MARGIN_US) * CLK_MHZ;

  // ==========================================================
  // pins driven toward the flash
  typedef struct packed {
    logic reset_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe_n;
    logic [21:0] addr;
    logic [7:0] dq_out;
  } flash_bus_t;

  localparam flash_bus_t FLASH_IDLE = '{reset_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                         dq_oe_n: 1'b1, addr: 22'h000000, dq_out: 8'h00};
endpackage

// [verif/flash_dev_model.sv]
// ==========================================================
// behavioural byte-wide flash, counts in 10 ns ticks
module flash_dev_model #(
  parameter int PROG_T = 50,
  parameter int ERASE_T = 500,
  parameter int WIN_T = 300,
  parameter int SUSP_T = 100
) (
  input wire flash_host_pkg::flash_bus_t bus,
  output logic [7:0] dq,
  output logic rb_low
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [2:0] {RD, PROG, CHIP, WIN, ERASE, SUSP} mode_t;
  mode_t mode = RD;
  int step = 0;
  int pc = 0;
  int wc = 0;
  int ec = 0;
  int sc = 0;
  int n_wr = 0;
  bit susp_req = 1'b0;
  bit in_susp = 1'b0;
  bit tog = 1'b0;
  bit [63:0] sel = '0;
  logic [21:0] a_lat = '0;
  logic [21:0] pa = '0;
  logic [7:0] pd = '0;
  logic [7:0] last = 8'h00;
  logic [7:0] mem [logic [21:0]];

  function automatic logic [7:0] rd_mem(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // erase leaves ones; the internal preprogram to zero is invisible here
  function automatic void wipe(input bit all);
    foreach (mem[k]) if (all || sel[k[21:16]]) mem[k] = 8'hFF;
  endfunction

  // ==========================================================
  // command decoder
  always @(negedge bus.we_n) a_lat = bus.addr; // we falls after ce, so later edge
  always @(posedge bus.we_n) if (!bus.ce_n && bus.oe_n && bus.reset_n) begin
    n_wr++;
    cmd(a_lat, bus.dq_out);
  end

  task automatic cmd(input logic [21:0] a, input logic [7:0] d);
    bit u1;
    bit u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2AA;
    case (mode)
      PROG, CHIP: ; // busy algorithms ignore all writes
      ERASE: if (d == 8'hB0 && !susp_req) begin // only suspend counts, resume repeats ignored
        susp_req = 1'b1;
        sc = SUSP_T;
      end
      WIN: if (d == 8'h30) begin // more sectors, timer restarts
        sel[a[21:16]] = 1'b1;
        wc = WIN_T;
      end else if (d == 8'hB0) mode = SUSP;
      else mode = RD;
      default: if (d == 8'hF0) step = 0; // leaving a command mode keeps suspend
      else if (mode == SUSP && step == 0 && d == 8'h30) begin
        mode = ERASE;
        susp_req = 1'b0;
      end else case (step)
        0: step = (u1 && d == 8'hAA) ? 1 : 0;
        1: step = (u2 && d == 8'h55) ? 2 : 0;
        2: step = (u1 && d == 8'hA0) ? 3 : (u1 && d == 8'h80 && mode == RD) ? 4 : 0;
        3: begin // any address order, suspended sectors refused
          step = 0;
          in_susp = mode == SUSP;
          if (!(in_susp && sel[a[21:16]])) begin
            pa = a;
            pd = d;
            pc = PROG_T;
            mode = PROG;
          end
        end
        4: step = (u1 && d == 8'hAA) ? 5 : 0;
        5: step = (u2 && d == 8'h55) ? 6 : 0;
        default: begin
          step = 0;
          pc = ERASE_T;
          ec = ERASE_T;
          wc = WIN_T;
          sel = '0;
          if (u1 && d == 8'h10) mode = CHIP;
          else if (d == 8'h30) sel[a[21:16]] = 1'b1;
          if (d == 8'h30) mode = WIN;
        end
      endcase
    endcase
  endtask

  // ==========================================================
  // algorithm time base, reset pin sampled every tick
  always #10 begin
    if (!bus.reset_n) begin
      mode = RD;
      step = 0;
      susp_req = 1'b0;
    end else case (mode)
      PROG: if (pc > 0) pc--;
      else begin // zeros stay zero; back to read or suspend
        mem[pa] = rd_mem(pa) & pd;
        mode = in_susp ? SUSP : RD;
      end
      CHIP: if (pc > 0) pc--;
      else begin
        wipe(1'b1);
        mode = RD;
      end
      WIN: if (wc > 0) wc--;
      else mode = ERASE;
      ERASE: if (susp_req) begin
        if (sc > 0) sc--;
        else mode = SUSP;
      end else if (ec > 0) ec--;
      else begin
        wipe(1'b0);
        mode = RD;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // outputs: busy pin and data lines; released lines show the inverse
  assign rb_low = mode inside {PROG, CHIP, WIN, ERASE};
  always @(negedge bus.oe_n) tog = !tog;
  always @(bus, mode, tog) begin
    if (!bus.ce_n && !bus.oe_n) begin // polling, toggles, window flag
      if (mode == RD || mode == SUSP && !sel[bus.addr[21:16]]) last = rd_mem(bus.addr);
      else last = {mode == SUSP, tog, 2'b00, mode != WIN, tog, 2'b00};
      dq = last;
    end else dq = ~last;
  end
endmodule // flash_dev_model

// [verif/tb_flash_host_ctrl.sv]
module tb_flash_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [7:0] dq;
  logic rb_low;
  flash_host_pkg::flash_bus_t fq;
  int err_count = 0;
  int n_checks = 0;
  int n0;

  always #5 clock = ~clock;

  flash_host_ctrl #(.WINDOW_CYCLES(200)) u_flash_host_ctrl (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .flash_q(fq), .flash_dq_in(dq), .ready_busy_n(~rb_low));
  flash_dev_model u_flash_dev_model (.bus(fq), .dq(dq), .rb_low(rb_low));

  // ==========================================================
  // bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask

  task automatic poll(input bit full);
    int n;
    n = 0;
    do begin
      wb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
      n++;
    end while ((q[flash_host_pkg::ST_BUSY_BIT] !== 1'b0 || full && q[flash_host_pkg::ST_RDY_BIT] !== 1'b1) && n < 3000);
    if (n >= 3000) chk("idle", 32'h1, 32'h0);
  endtask

  // w: 0 waits for the sequencer, 1 also for the pin, 2 returns at once
  task automatic op(input logic [2:0] o, input logic [21:0] a, input logic [7:0] d, input int w);
    wb(1'b1, flash_host_pkg::REG_ADDR, {10'h0, a});
    wb(1'b1, flash_host_pkg::REG_WDATA, {24'h0, d});
    wb(1'b1, flash_host_pkg::REG_CTRL, {29'h0, o});
    if (w < 2) poll(w == 1);
  endtask

  task automatic fr(input logic [21:0] a);
    op(flash_host_pkg::OP_READ, a, 8'h00, 0);
    wb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // tests; watchdog sized well above the tens of microseconds used
  initial begin
    #500000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h2, q);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    n0 = u_flash_dev_model.n_wr;
    op(flash_host_pkg::OP_PROGRAM, 22'h012345, 8'h5A, 1);
    chk("program writes", 32'd4, 32'(u_flash_dev_model.n_wr - n0));
    fr(22'h012345);
    chk("programmed", 32'h5A, q);
    op(flash_host_pkg::OP_PROGRAM, 22'h3F0001, 8'hC3, 1);
    fr(22'h3F0001);
    chk("other sector", 32'hC3, q);
    op(flash_host_pkg::OP_PROGRAM, 22'h012345, 8'hA5, 1);
    fr(22'h012345);
    chk("only clears", 32'h00, q);
    $display("test program done");
    op(flash_host_pkg::OP_PROGRAM, 22'h070000, 8'h00, 2);
    repeat (45) @(posedge clock);
    chk("busy pin", 32'h1, {31'h0, rb_low});
    wb(1'b1, flash_host_pkg::REG_CTRL, {29'h0, flash_host_pkg::OP_CHIP_ERASE});
    wb(1'b1, flash_host_pkg::REG_CTRL, 32'h100);
    poll(1);
    chk("refused", 32'h1, {31'h0, q[flash_host_pkg::ST_REFUSED_BIT]});
    fr(22'h070000);
    chk("aborted", 32'hFF, q);
    wb(1'b1, flash_host_pkg::REG_STATUS, 32'h4);
    wb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    chk("refused cleared", 32'h2, q);
    $display("test abort done");
    n0 = u_flash_dev_model.n_wr;
    op(flash_host_pkg::OP_CHIP_ERASE, 22'h0, 8'h00, 1);
    chk("chip writes", 32'd6, 32'(u_flash_dev_model.n_wr - n0));
    fr(22'h3F0001);
    chk("chip erased", 32'hFF, q);
    $display("test chip erase done");
    op(flash_host_pkg::OP_PROGRAM, 22'h020000, 8'h00, 1);
    op(flash_host_pkg::OP_PROGRAM, 22'h030000, 8'h00, 1);
    n0 = u_flash_dev_model.n_wr;
    op(flash_host_pkg::OP_SECTOR_ERASE, 22'h020000, 8'h00, 0);
    chk("window", 32'h1, {31'h0, q[flash_host_pkg::ST_WINDOW_BIT]});
    op(flash_host_pkg::OP_ADD_SECTOR, 22'h030000, 8'h00, 1);
    chk("sector writes", 32'd7, 32'(u_flash_dev_model.n_wr - n0));
    fr(22'h030000);
    chk("added sector", 32'hFF, q);
    $display("test sector erase done");
    op(flash_host_pkg::OP_PROGRAM, 22'h050000, 8'h11, 1);
    op(flash_host_pkg::OP_SECTOR_ERASE, 22'h050000, 8'h00, 0);
    op(flash_host_pkg::OP_SUSPEND, 22'h0, 8'h00, 1);
    fr(22'h050000);
    chk("suspended poll", 32'h1, {31'h0, q[7]});
    op(flash_host_pkg::OP_PROGRAM, 22'h060000, 8'h22, 1);
    fr(22'h060000);
    chk("program in suspend", 32'h22, q);
    op(flash_host_pkg::OP_RESUME, 22'h0, 8'h00, 1);
    fr(22'h050000);
    chk("resumed erase", 32'hFF, q);
    $display("test suspend done");
    op(flash_host_pkg::OP_PROGRAM, 22'h080000, 8'h00, 1);
    op(flash_host_pkg::OP_SECTOR_ERASE, 22'h080000, 8'h00, 0);
    op(flash_host_pkg::OP_RESET_CMD, 22'h0, 8'h00, 1);
    fr(22'h080000);
    chk("window cancelled", 32'h00, q);
    n0 = u_flash_dev_model.n_wr;
    op(flash_host_pkg::OP_ADD_SECTOR, 22'h080000, 8'h00, 0);
    chk("late add refused", 32'h1, {31'h0, q[flash_host_pkg::ST_REFUSED_BIT]});
    chk("late add writes", 32'h0, 32'(u_flash_dev_model.n_wr - n0));
    $display("test window cancel done");
    conclude();
  end
endmodule // tb_flash_host_ctrl
